// >>> core/ltb_pkg.sv
package ltb_pkg;

    // AXI4-Lite register map (byte addresses).
    localparam logic [7:0] LTB_USB_CONTROL_REG_OFS       = 8'h00;
    localparam logic [7:0] LTB_OTG_CONTROL_REG_OFS       = 8'h04;
    localparam logic [7:0] LTB_USB_POWER_CTL_REG_OFS     = 8'h08;
    localparam logic [7:0] LTB_BOOST_PWM_RATE_REG_OFS    = 8'h0C;
    localparam logic [7:0] LTB_BOOST_PWM_CONTROL_REG_OFS = 8'h10;
    localparam logic [7:0] LTB_STATUS_REG_OFS            = 8'h14;

    // Field positions in the usb control register.
    localparam int LTB_USB_MODULE_ENABLE_BIT = 0;
    localparam int LTB_HOST_ROLE_ENABLE_BIT  = 3;
    localparam int LTB_SUSPEND_BIT           = 1;

    // Field positions in the otg control register.
    localparam int LTB_VBUS_DISCHARGE_BIT    = 0;
    localparam int LTB_VBUS_TARGET_SEL_BIT   = 1;
    localparam int LTB_PIN_OVERRIDE_BIT      = 2;
    localparam int LTB_VBUS_GEN_ENABLE_BIT   = 3;
    localparam int LTB_DMINUS_PULLDOWN_BIT   = 4;
    localparam int LTB_DPLUS_PULLDOWN_BIT    = 5;
    localparam int LTB_DPLUS_PULLUP_BIT      = 7;

    // Field positions in the power and pwm registers.
    localparam int LTB_MODULE_POWER_BIT      = 0;
    localparam int LTB_PWM_PERIOD_LSB        = 0;
    localparam int LTB_PWM_DUTY_LSB          = 8;
    localparam int LTB_BOOST_COUNTER_EN_BIT  = 8;
    localparam int LTB_BOOST_POLARITY_BIT    = 9;
    localparam int LTB_BOOST_PWM_EN_BIT      = 15;

    // Reset values.
    localparam logic [15:0] LTB_USB_CONTROL_RST       = 16'h0000;
    localparam logic [15:0] LTB_OTG_CONTROL_RST       = 16'h0000;
    localparam logic [15:0] LTB_USB_POWER_CTL_RST     = 16'h0000;
    localparam logic [15:0] LTB_BOOST_PWM_RATE_RST    = 16'h0000;
    localparam logic [15:0] LTB_BOOST_PWM_CONTROL_RST = 16'h0000;

    // AXI responses.
    localparam logic [1:0] LTB_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LTB_RESP_SLVERR = 2'h2;

    // Line termination as driven toward the transceiver.
    typedef struct packed {
        logic dplus_pullup;
        logic dplus_pulldown;
        logic dminus_pulldown;
    } ltb_term_t;

    // Boost supply controls.
    typedef struct packed {
        logic pwm_out;
        logic vbus_target_select;
        logic vbus_gen_enable;
        logic vbus_discharge;
    } ltb_boost_t;

endpackage : ltb_pkg

// >>> core/ltb_line_term_boost.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
// Behaviour
// [RQ1] Device mode: D+ pull-up on while module enabled and override clear.
// [RQ2] Override set: D+ pull-up follows only its own control bit.
// [RQ3] Host role enable connects both pull-downs while override clear.
// [RQ4] Override set: each pull-down follows its own control bit.
// [RQ5] Software checks module power and keeps discharge low before VBUS generation.
// [RQ6] PWM period from rate bits 7:0, duty from bits 15:8.
// [RQ7] PWM control bit 9 selects output polarity.
// [RQ8] Otg control bit 1 selects the VBUS target voltage.
// [RQ9] PWM counter runs only while counter enable bit 8 is set.
// [RQ10] PWM output active only while PWM enable bit 15 is set.
// [RQ11] VBUS generation operates only while otg control bit 3 is set.
// [RQ12] Self-powered designs keep module and pull-up off until VBUS seen.
// [RQ13] Pull-up stays connected during bus suspend.
// [RQ14] Output high while count below duty, wraps at period, inverted by polarity.
module ltb_line_term_boost
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst_n,
    // AXI4-Lite write address channel.
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    // AXI4-Lite write response channel.
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    // AXI4-Lite read data channel.
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Power state from the analog block.
    input  wire logic                module_powered,
    // Line termination and boost supply controls.
    output      ltb_pkg::ltb_term_t  term,
    output      ltb_pkg::ltb_boost_t boost
);
    import ltb_pkg::*;

    logic [15:0] usb_control_reg;
    logic [15:0] otg_control_reg;
    logic [15:0] usb_power_ctl_reg;
    logic [15:0] boost_pwm_rate_reg;
    logic [15:0] boost_pwm_control_reg;
    logic [7:0]  pwm_count;
    logic [2:0]  pwr_sync;
    logic        pwr_level;

    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    logic        wr_fire;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    ltb_term_t   next_term;
    ltb_boost_t  next_boost;
    logic        pin_override_enable;
    logic        boost_counter_enable;
    logic        boost_pwm_enable;
    logic        boost_pwm_polarity;
    logic [7:0]  pwm_period;
    logic [7:0]  pwm_duty;

    // Merge a 16-bit register with the low two byte lanes of a write.
    function automatic logic [15:0] ltb_merge(input logic [15:0] old_val, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [15:0] res;
        res = old_val;
        if (strb[0])
        begin
            res[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : ltb_merge

    function automatic logic ltb_mapped(input logic [7:0] addr);
        return addr == LTB_USB_CONTROL_REG_OFS || addr == LTB_OTG_CONTROL_REG_OFS ||
               addr == LTB_USB_POWER_CTL_REG_OFS || addr == LTB_BOOST_PWM_RATE_REG_OFS ||
               addr == LTB_BOOST_PWM_CONTROL_REG_OFS || addr == LTB_STATUS_REG_OFS;
    endfunction : ltb_mapped

    // The power-good level comes from the analog domain; three stages, change on agreement.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_sync  <= 3'h0;
            pwr_level <= 1'b0;
        end
        else
        begin
            pwr_sync <= {pwr_sync[1:0], module_powered};
            if (pwr_sync[1] == pwr_sync[2])
            begin
                pwr_level <= pwr_sync[2];
            end
        end
    end

    // Write channel: address and data are caught independently, in either order.
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit  = ltb_mapped(aw_addr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= LTB_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? LTB_RESP_OKAY : LTB_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register storage; the status word is read-only.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usb_control_reg       <= LTB_USB_CONTROL_RST;
            otg_control_reg       <= LTB_OTG_CONTROL_RST;
            usb_power_ctl_reg     <= LTB_USB_POWER_CTL_RST;
            boost_pwm_rate_reg    <= LTB_BOOST_PWM_RATE_RST;
            boost_pwm_control_reg <= LTB_BOOST_PWM_CONTROL_RST;
        end
        else if (wr_fire)
        begin
            unique case (aw_addr)
                LTB_USB_CONTROL_REG_OFS:
                    usb_control_reg <= ltb_merge(usb_control_reg, w_data, w_strb);
                LTB_OTG_CONTROL_REG_OFS:
                    otg_control_reg <= ltb_merge(otg_control_reg, w_data, w_strb);
                LTB_USB_POWER_CTL_REG_OFS:
                    usb_power_ctl_reg <= ltb_merge(usb_power_ctl_reg, w_data, w_strb);
                LTB_BOOST_PWM_RATE_REG_OFS:
                    boost_pwm_rate_reg <= ltb_merge(boost_pwm_rate_reg, w_data, w_strb);
                LTB_BOOST_PWM_CONTROL_REG_OFS:
                    boost_pwm_control_reg <= ltb_merge(boost_pwm_control_reg, w_data, w_strb);
                default:
                begin
                end
            endcase
        end
    end

    // Read channel: one cycle from address acceptance to data.
    assign rd_hit = ltb_mapped(s_axi_araddr);

    always_comb
    begin
        rd_word = 32'h00000000;
        unique case (s_axi_araddr)
            LTB_USB_CONTROL_REG_OFS:       rd_word[15:0] = usb_control_reg;
            LTB_OTG_CONTROL_REG_OFS:       rd_word[15:0] = otg_control_reg;
            LTB_USB_POWER_CTL_REG_OFS:
            begin
                rd_word[15:0] = usb_power_ctl_reg;
                // Software polls this bit before starting VBUS generation.
                rd_word[LTB_MODULE_POWER_BIT] = pwr_level; // [RQ5]
            end
            LTB_BOOST_PWM_RATE_REG_OFS:    rd_word[15:0] = boost_pwm_rate_reg;
            LTB_BOOST_PWM_CONTROL_REG_OFS: rd_word[15:0] = boost_pwm_control_reg;
            LTB_STATUS_REG_OFS:            rd_word = {20'h00000, pwm_count, term, boost.pwm_out};
            default:                       rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= LTB_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? LTB_RESP_OKAY : LTB_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Line termination.
    assign pin_override_enable = otg_control_reg[LTB_PIN_OVERRIDE_BIT];

    always_comb
    begin
        if (pin_override_enable)
        begin
            next_term.dplus_pullup    = otg_control_reg[LTB_DPLUS_PULLUP_BIT]; // [RQ2]
            next_term.dplus_pulldown  = otg_control_reg[LTB_DPLUS_PULLDOWN_BIT]; // [RQ4]
            next_term.dminus_pulldown = otg_control_reg[LTB_DMINUS_PULLDOWN_BIT]; // [RQ4]
        end
        else
        begin
            // Suspend state is deliberately not a term here, so the pull-up holds through it.
            next_term.dplus_pullup    = usb_control_reg[LTB_USB_MODULE_ENABLE_BIT] &&
                                        !usb_control_reg[LTB_HOST_ROLE_ENABLE_BIT]; // [RQ1] [RQ13]
            next_term.dplus_pulldown  = usb_control_reg[LTB_HOST_ROLE_ENABLE_BIT]; // [RQ3]
            next_term.dminus_pulldown = usb_control_reg[LTB_HOST_ROLE_ENABLE_BIT]; // [RQ3]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            term <= '0;
        end
        else
        begin
            term <= next_term;
        end
    end

    // Boost PWM.
    assign pwm_period           = boost_pwm_rate_reg[LTB_PWM_PERIOD_LSB +: 8]; // [RQ6]
    assign pwm_duty             = boost_pwm_rate_reg[LTB_PWM_DUTY_LSB +: 8]; // [RQ6]
    assign boost_counter_enable = boost_pwm_control_reg[LTB_BOOST_COUNTER_EN_BIT];
    assign boost_pwm_enable     = boost_pwm_control_reg[LTB_BOOST_PWM_EN_BIT];
    assign boost_pwm_polarity   = boost_pwm_control_reg[LTB_BOOST_POLARITY_BIT];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_count <= 8'h00;
        end
        else if (!boost_counter_enable) // [RQ9]
        begin
            pwm_count <= 8'h00;
        end
        else if (pwm_count >= pwm_period) // [RQ14]
        begin
            pwm_count <= 8'h00;
        end
        else
        begin
            pwm_count <= pwm_count + 8'h01;
        end
    end

    always_comb
    begin
        next_boost.vbus_gen_enable    = otg_control_reg[LTB_VBUS_GEN_ENABLE_BIT]; // [RQ11]
        next_boost.vbus_target_select = otg_control_reg[LTB_VBUS_TARGET_SEL_BIT]; // [RQ8]
        next_boost.vbus_discharge     = otg_control_reg[LTB_VBUS_DISCHARGE_BIT];
        // A disabled PWM parks at its inactive level, which follows the polarity choice.
        next_boost.pwm_out = ((boost_pwm_enable && boost_counter_enable && next_boost.vbus_gen_enable &&
                               pwm_count < pwm_duty) ^ boost_pwm_polarity); // [RQ10] [RQ14] [RQ7]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost <= '0;
        end
        else
        begin
            boost <= next_boost;
        end
    end

endmodule : ltb_line_term_boost

// >>> tb/ltb_line_term_boost_asserts.sv
`timescale 1ns/10ps
module ltb_line_term_boost_asserts
    import ltb_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Write channels.
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    input  wire logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic                s_axi_wvalid,
    input  wire logic                s_axi_wready,
    input  wire logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // Controls.
    input  wire ltb_pkg::ltb_term_t  term,
    input  wire ltb_pkg::ltb_boost_t boost
);
    logic [7:0]  wa;
    logic [15:0] wd, usb, otg, rate, pwmc;
    logic        ga, gw, hi, act;
    logic [1:0]  settle;
    logic [8:0]  hi_run, lo_run;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Shadow copies follow committed writes, so checks see what software asked for.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {ga, gw, wa, wd, usb, otg, rate, pwmc} <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready) {ga, wa} <= {1'b1, s_axi_awaddr};
            if (s_axi_wvalid && s_axi_wready) {gw, wd} <= {1'b1, s_axi_wdata[15:0]};
            if (ga && gw)
            begin
                {ga, gw} <= 2'h0;
                if (wa == LTB_USB_CONTROL_REG_OFS) usb <= wd;
                if (wa == LTB_OTG_CONTROL_REG_OFS) otg <= wd;
                if (wa == LTB_BOOST_PWM_RATE_REG_OFS) rate <= wd;
                if (wa == LTB_BOOST_PWM_CONTROL_REG_OFS) pwmc <= wd;
            end
        end
    end

    // Run lengths restart after a write because the pwm phase is then unknown.
    assign hi  = boost.pwm_out ^ pwmc[9];
    assign act = pwmc[15] & pwmc[8] & otg[3] & (settle == 2'h0) & (rate[15:8] <= rate[7:0]) & (rate[15:8] != 8'h00);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {settle, hi_run, lo_run} <= '0;
        end
        else
        begin
            settle <= (ga && gw) ? 2'h3 : settle - {1'b0, settle != 2'h0};
            hi_run <= (settle != 2'h0 || !hi) ? 9'h000 : hi_run + 9'h001;
            lo_run <= (settle != 2'h0 || hi) ? 9'h000 : lo_run + 9'h001;
        end
    end

    sequence s_wr_done;
        s_axi_bvalid && s_axi_bready;
    endsequence

    a_pullup_auto: assert property (s_wr_done |=> otg[2] || term.dplus_pullup == (usb[0] && !usb[3]))
        else $error("pull-up wrong in automatic mode");
    a_pullup_ovr: assert property (s_wr_done |=> !otg[2] || term.dplus_pullup == otg[7])
        else $error("pull-up wrong under override");
    a_pulldn_auto: assert property (s_wr_done |=> otg[2] || {term.dplus_pulldown, term.dminus_pulldown} == {2{usb[3]}})
        else $error("pull-downs wrong in automatic mode");
    a_pulldn_ovr: assert property (s_wr_done |=> !otg[2] || {term.dplus_pulldown, term.dminus_pulldown} == otg[5:4])
        else $error("pull-downs wrong under override");
    a_target_sel: assert property (s_wr_done |=> boost.vbus_target_select == otg[1] && boost.vbus_gen_enable == otg[3] &&
                                  boost.vbus_discharge == otg[0])
        else $error("target, generation enable or discharge wrong");
    a_pwm_idle: assert property (s_wr_done |=> (pwmc[15] && pwmc[8] && otg[3]) || boost.pwm_out == pwmc[9])
        else $error("pwm active while disabled");
    a_duty_high: assert property (act |-> hi_run <= {1'b0, rate[15:8]})
        else $error("pwm active phase too long");
    a_duty_low: assert property (act |-> lo_run <= {1'b0, rate[7:0]} + 9'h001 - {1'b0, rate[15:8]})
        else $error("pwm idle phase too long");
endmodule : ltb_line_term_boost_asserts

bind ltb_line_term_boost ltb_line_term_boost_asserts ltb_line_term_boost_asserts_inst (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .term(term), .boost(boost));

// >>> tb/ltb_far_side.sv
`timescale 1ns/10ps
module ltb_far_side
    import ltb_pkg::*;
(
    // Clock and supply state.
    input  wire logic                clk,
    input  wire logic                power_on,
    // Controls from the block.
    input  wire ltb_pkg::ltb_term_t  term,
    input  wire ltb_pkg::ltb_boost_t boost,
    // Line and supply levels.
    output      logic                module_powered,
    output      logic                dplus_level,
    output      logic                vbus_seen
);
    logic pwr_d;

    // The analog supply settles slowly, so power is reported two cycles late.
    always @(posedge clk)
    begin
        pwr_d <= power_on;
        module_powered <= pwr_d;
        vbus_seen <= power_on | boost.vbus_gen_enable;
    end

    // An unterminated line floats; showing the inverse of the last level exposes it.
    always @(posedge clk)
    begin
        if (term.dplus_pullup) dplus_level <= 1'b1;
        else if (term.dplus_pulldown) dplus_level <= 1'b0;
        else dplus_level <= ~dplus_level;
    end
endmodule : ltb_far_side

// >>> tb/ltb_line_term_boost_tb.sv
`timescale 1ns/10ps
module ltb_line_term_boost_tb;
    import ltb_pkg::*;
    logic        clk, rst_n, awv, wv, bv, br, arv, rv, rr, awr, wr_, arr, pwr, mp, dpl, vseen;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd_;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] d;
    logic [31:0] i;
    ltb_term_t   term;
    ltb_boost_t  boost;
    int          n_fail, compares, cyc;

    ltb_line_term_boost ltb_line_term_boost_inst (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .module_powered(mp), .term(term), .boost(boost));
    ltb_far_side ltb_far_side_inst (.clk(clk), .power_on(pwr), .term(term), .boost(boost),
        .module_powered(mp), .dplus_level(dpl), .vbus_seen(vseen));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task final_report;
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Both write channels are offered together; settles to the falling edge after the response.
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {awa, wd, awv, wv, br} <= {a, v, 3'h7};
        r = 2'h3;
        while (r === 2'h3)
        begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
            if (bv) r = bresp;
        end
        br <= 1'b0;
        @(negedge clk);
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk);
        {ara, arv, rr} <= {a, 2'h3};
        r = 2'h3;
        while (r === 2'h3)
        begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) {r, d} = {rresp, rd_};
        end
        rr <= 1'b0;
        @(negedge clk);
    endtask : rd

    task cnt_hi;
        i = 0;
        repeat (16)
        begin
            @(negedge clk);
            i += boost.pwm_out;
        end
    endtask : cnt_hi

    task t_reset;
        for (int a = 0; a <= 20; a += 4)
        begin
            rd(8'(a));
            chk(d, 32'h0);
        end
        chk(32'({term, boost}), 32'h0);
    endtask : t_reset

    task t_auto;
        pwr <= 1'b1;
        wait (vseen === 1'b1);
        wr(LTB_USB_CONTROL_REG_OFS, 32'hABCD0001);
        chk(32'(term), 32'h4);
        // The line model follows the termination one clock later.
        @(negedge clk);
        chk(32'(dpl), 32'h1);
        rd(LTB_USB_CONTROL_REG_OFS);
        chk(d, 32'h1);
        wr(LTB_USB_CONTROL_REG_OFS, 32'h3);
        chk(32'(term), 32'h4);
        wr(LTB_USB_CONTROL_REG_OFS, 32'h9);
        chk(32'(term), 32'h3);
        @(negedge clk);
        chk(32'(dpl), 32'h0);
    endtask : t_auto

    task t_override;
        for (int k = 0; k < 8; k++)
        begin
            wr(LTB_OTG_CONTROL_REG_OFS, {24'h0, k[2], 1'b0, k[1:0], 4'h4});
            chk(32'(term), 32'(k));
        end
        wr(LTB_OTG_CONTROL_REG_OFS, 32'h0);
    endtask : t_override

    task t_boost;
        wr(LTB_OTG_CONTROL_REG_OFS, 32'h1);
        chk(32'(boost), 32'h1);
        // Discharge is dropped again before the enable sequence starts.
        wr(LTB_OTG_CONTROL_REG_OFS, 32'h0);
        rd(LTB_USB_POWER_CTL_REG_OFS);
        chk(d, 32'h1);
        wr(LTB_BOOST_PWM_RATE_REG_OFS, 32'h0307);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h0200);
        wr(LTB_OTG_CONTROL_REG_OFS, 32'h2);
        chk(32'(boost), 32'hC);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h0300);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h8300);
        wr(LTB_OTG_CONTROL_REG_OFS, 32'hA);
        chk(32'(boost.vbus_gen_enable), 32'h1);
        cnt_hi();
        chk(i, 10);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h8100);
        cnt_hi();
        chk(i, 6);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h8000);
        cnt_hi();
        chk(i, 0);
        // The status word shows the counter parked at zero beside the host termination.
        rd(LTB_STATUS_REG_OFS);
        chk(d, 32'h6);
        wr(LTB_BOOST_PWM_CONTROL_REG_OFS, 32'h0100);
        cnt_hi();
        chk(i, 0);
    endtask : t_boost

    task t_unmapped;
        wr(8'h18, 32'hFFFF);
        chk(32'(r), 32'(LTB_RESP_SLVERR));
        rd(8'h18);
        chk({d[29:0], r}, 32'(LTB_RESP_SLVERR));
    endtask : t_unmapped

    initial
    begin
        {rst_n, awv, wv, br, arv, rr, pwr, awa, ara, wd} = '0;
        {n_fail, compares, cyc} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_auto();
        t_override();
        t_boost();
        t_unmapped();
        final_report();
    end
endmodule : ltb_line_term_boost_tb
